// >>> dv/dpb_link_asserts.sv
// Concurrent checks on the link between the controller and the burst memory
`timescale 1ns/1ns
module dpb_link_asserts #(
    parameter int DATA_W = dpb_pkg::DATA_W_NARROW,
    parameter int ADDR_W = dpb_pkg::ADDR_W_NARROW,
    parameter int LANES = DATA_W / dpb_pkg::LANE_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic k_true,
    input wire logic k_comp,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [LANES-1:0] byte_lane_write_select_n,
    input wire logic [DATA_W-1:0] q_out,
    input wire logic q_oe,
    input wire logic [DATA_W-1:0] q_bus,
    input wire logic read_valid_flag,
    input wire logic echo_timing_output,
    input wire logic echo_timing_output_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Read start and its two beats
    sequence s_read_start;
        k_true && !read_port_select_n;
    endsequence
    sequence s_two_beats;
        (q_oe && read_valid_flag && !k_true) ##1 (q_oe && read_valid_flag && k_true);
    endsequence

    a_read_beats: assert property (s_read_start |-> ##5 s_two_beats)
        else $error("read beats not at expected cycles");
    a_oe_cause: assert property (q_oe |-> $past(!read_port_select_n && k_true, 5)
        || $past(!read_port_select_n && k_true, 6))
        else $error("read drivers on without a read");
    a_oe_valid: assert property (q_oe == read_valid_flag)
        else $error("valid flag and drive enable differ");
    a_echo_follow: assert property (echo_timing_output == $past(k_true)
        && echo_timing_output_n == !echo_timing_output)
        else $error("echo outputs misaligned");
    a_comp_inverse: assert property (k_comp == !k_true)
        else $error("clock phases not complementary");
    a_rsel_phase: assert property (!read_port_select_n |-> k_true)
        else $error("read select outside true phase");
    a_wsel_phase: assert property (!write_port_select_n |-> k_true)
        else $error("write select outside true phase");
    a_wsel_pulse: assert property (!write_port_select_n
        |=> write_port_select_n && k_comp)
        else $error("write select not a single pulse");
    a_phase_alt: assert property (k_true |=> !k_true)
        else $error("true phase held two cycles");
    a_bus_drive: assert property (q_oe |-> q_bus == q_out)
        else $error("read bus differs from driver");

    c_read: cover property (s_read_start ##5 s_two_beats);
endmodule : dpb_link_asserts

// >>> dv/tb.sv
// Testbench joining controller and burst memory across the link
`timescale 1ns/1ns
module tb;
    localparam int DW = dpb_pkg::DATA_W_NARROW;
    localparam int AW = dpb_pkg::ADDR_W_NARROW;
    localparam int LN = DW / dpb_pkg::LANE_W;

    logic ref_clk;
    logic reset_n;
    logic rd_req_valid;
    logic rd_req_ready;
    logic [AW-1:0] rd_req_addr;
    logic wr_req_valid;
    logic wr_req_ready;
    logic [AW-1:0] wr_req_addr;
    logic [DW-1:0] wr_data0;
    logic [DW-1:0] wr_data1;
    logic [LN-1:0] wr_lane_en0;
    logic [LN-1:0] wr_lane_en1;
    logic rd_data_valid;
    logic rd_data_ready;
    logic [DW-1:0] rd_data;
    int n_fail;
    int n_tests;

    ////////////////////////////////////////////////////////////////////////////////
    // Both ends and the link checker
    dpb_link_if #(.DATA_W(DW), .ADDR_W(AW)) link ();
    dpb_mem_ctl #(.DATA_W(DW), .ADDR_W(AW)) dpb_mem_ctl_i (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr),
        .wr_req_valid(wr_req_valid), .wr_req_ready(wr_req_ready), .wr_req_addr(wr_req_addr),
        .wr_data0(wr_data0), .wr_data1(wr_data1),
        .wr_lane_en0(wr_lane_en0), .wr_lane_en1(wr_lane_en1),
        .rd_data_valid(rd_data_valid), .rd_data_ready(rd_data_ready), .rd_data(rd_data),
        .link(link.ctl)
    );
    dpb_mem_dev #(.DATA_W(DW), .ADDR_W(AW), .MEM_AW(4)) dpb_mem_dev_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .link(link.dev)
    );
    dpb_link_asserts #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) dpb_link_asserts_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .k_true(link.k_true), .k_comp(link.k_comp),
        .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n),
        .addr(link.addr), .wdata(link.wdata),
        .byte_lane_write_select_n(link.byte_lane_write_select_n),
        .q_out(link.q_out), .q_oe(link.q_oe), .q_bus(link.q_bus),
        .read_valid_flag(link.read_valid_flag), .echo_timing_output(link.echo_timing_output),
        .echo_timing_output_n(link.echo_timing_output_n)
    );

    // Clock source
    initial begin
        ref_clk = 1'b0;
        forever #(dpb_pkg::REF_CLK_NS / 2) ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Expected word after a lane-masked write
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                            input logic [LN-1:0] en);
        merge = o;
        for (int i = 0; i < LN; i++) begin
            if (en[i]) begin
                merge[i*dpb_pkg::LANE_W +: dpb_pkg::LANE_W] =
                    n[i*dpb_pkg::LANE_W +: dpb_pkg::LANE_W];
            end
        end
    endfunction : merge

    // Posted write, held until taken
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                      input logic [LN-1:0] e0, input logic [LN-1:0] e1);
        int n;
        @(posedge ref_clk);
        wr_req_valid <= 1'b1;
        wr_req_addr <= a;
        wr_data0 <= d0;
        wr_data1 <= d1;
        wr_lane_en0 <= e0;
        wr_lane_en1 <= e1;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (wr_req_ready !== 1'b1 && n < 10);
        @(posedge ref_clk);
        wr_req_valid <= 1'b0;
        chk(n < 10, "write not taken");
    endtask : wr

    // Read burst, optional stall of the receiver
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e0, input logic [DW-1:0] e1,
                      input int stall);
        int n;
        int k;
        logic [DW-1:0] wb [2];
        @(posedge ref_clk);
        rd_req_valid <= 1'b1;
        rd_req_addr <= a;
        rd_data_ready <= (stall == 0);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (rd_req_ready !== 1'b1 && n < 10);
        @(posedge ref_clk);
        rd_req_valid <= 1'b0;
        n = 0;
        k = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (link.read_valid_flag === 1'b1 && k < 2) begin
                wb[k] = link.q_bus;
                k++;
            end
        end while (rd_data_valid !== 1'b1 && n < 20);
        if (stall == 0) chk(n == 7, "read latency");
        chk(k == 2 && wb[0] === e0 && wb[1] === e1, "link beats");
        if (stall > 0) begin
            repeat (stall) @(negedge ref_clk);
            chk(rd_req_ready === 1'b0 && rd_data === e0, "stalled buffer lost word");
            @(posedge ref_clk);
            rd_data_ready <= 1'b1;
            @(negedge ref_clk);
        end
        chk(rd_data_valid === 1'b1 && rd_data === e0, "first word");
        @(negedge ref_clk);
        chk(rd_data_valid === 1'b1 && rd_data === e1, "second word");
        @(negedge ref_clk);
        chk(rd_data_valid === 1'b0 && link.q_oe === 1'b0, "burst not ended");
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset;
        @(negedge ref_clk);
        chk(link.q_oe === 1'b0 && link.read_valid_flag === 1'b0, "outputs idle");
        chk(link.read_port_select_n === 1'b1 && link.write_port_select_n === 1'b1,
            "selects");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_basic;
        wr(20'h00002, 18'h12345, 18'h2ABCD, 2'h3, 2'h3);
        wr(20'h00003, 18'h00F0F, 18'h3F0F0, 2'h3, 2'h3);
        rd(20'h00002, 18'h12345, 18'h2ABCD, 0);
        rd(20'h00003, 18'h00F0F, 18'h3F0F0, 0);
        $display("test_basic done");
    endtask : test_basic

    task automatic test_lanes;
        logic [LN-1:0] en;
        logic [DW-1:0] x0;
        logic [DW-1:0] x1;
        for (int i = 0; i < LN; i++) begin
            en = 2'h1 << i;
            x0 = merge(18'h15555, 18'h0C3C3, en);
            x1 = merge(18'h2AAAA, 18'h33C3C, ~en);
            wr(20'h00004, 18'h15555, 18'h2AAAA, 2'h3, 2'h3);
            wr(20'h00004, 18'h0C3C3, 18'h33C3C, en, ~en);
            rd(20'h00004, x0, x1, 0);
            wr(20'h00004, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
            rd(20'h00004, x0, x1, 0);
        end
        $display("test_lanes done");
    endtask : test_lanes

    task automatic test_stall;
        wr(20'h00005, 18'h3C0C3, 18'h03C3C, 2'h3, 2'h3);
        rd(20'h00005, 18'h3C0C3, 18'h03C3C, 5);
        $display("test_stall done");
    endtask : test_stall

    // Reset in mid-burst drops it; storage survives
    task automatic test_mid_reset;
        wr(20'h00006, 18'h1E1E1, 18'h21E1E, 2'h3, 2'h3);
        @(posedge ref_clk);
        rd_req_valid <= 1'b1;
        rd_req_addr <= 20'h00006;
        do begin
            @(negedge ref_clk);
        end while (rd_req_ready !== 1'b1);
        @(posedge ref_clk);
        rd_req_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk(link.q_oe === 1'b0 && rd_data_valid === 1'b0, "burst not dropped");
        chk(rd_req_ready === 1'b1 && wr_req_ready === 1'b1, "not ready after reset");
        rd(20'h00006, 18'h1E1E1, 18'h21E1E, 0);
        $display("test_mid_reset done");
    endtask : test_mid_reset

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_fail = 0;
        n_tests = 0;
        reset_n = 1'b0;
        rd_req_valid = 1'b0;
        rd_req_addr = 20'h00000;
        wr_req_valid = 1'b0;
        wr_req_addr = 20'h00000;
        wr_data0 = 18'h00000;
        wr_data1 = 18'h00000;
        wr_lane_en0 = 2'h0;
        wr_lane_en1 = 2'h0;
        rd_data_ready = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        test_reset();
        test_basic();
        test_lanes();
        test_stall();
        test_mid_reset();
        complete_run();
    end

    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : tb

// >>> verilog/dpb_link_if.sv
// Pin-level link between the memory controller and the burst memory
`timescale 1ns/1ns
interface dpb_link_if #(
    parameter int DATA_W = dpb_pkg::DATA_W_NARROW,
    parameter int ADDR_W = dpb_pkg::ADDR_W_NARROW,
    parameter int LANES = DATA_W / dpb_pkg::LANE_W
);
    // Input clocks as phase levels, true and complementary
    logic k_true;
    logic k_comp;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] byte_lane_write_select_n;
    // Read data driver, its enable and the resolved bus
    logic [DATA_W-1:0] q_out;
    logic q_oe;
    wire [DATA_W-1:0] q_bus;
    logic read_valid_flag;
    logic echo_timing_output;
    logic echo_timing_output_n;

    // Released read pins show the inverse of the last word, so late sampling shows up
    assign q_bus = q_oe ? q_out : ~q_out;

    modport dev (
        input k_true, k_comp, read_port_select_n, write_port_select_n, addr, wdata,
        input byte_lane_write_select_n,
        output q_out, q_oe, read_valid_flag, echo_timing_output, echo_timing_output_n
    );
    modport ctl (
        output k_true, k_comp, read_port_select_n, write_port_select_n, addr, wdata,
        output byte_lane_write_select_n,
        input q_bus, read_valid_flag, echo_timing_output, echo_timing_output_n
    );
endinterface : dpb_link_if

// >>> verilog/dpb_mem_ctl.sv
// Controller end: drives the burst memory link from user requests
`timescale 1ns/1ns
module dpb_mem_ctl #(
    parameter int DATA_W = dpb_pkg::DATA_W_NARROW,
    parameter int ADDR_W = dpb_pkg::ADDR_W_NARROW
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic rd_req_valid,
    output logic rd_req_ready,
    input wire logic [ADDR_W-1:0] rd_req_addr,
    input wire logic wr_req_valid,
    output logic wr_req_ready,
    input wire logic [ADDR_W-1:0] wr_req_addr,
    input wire logic [DATA_W-1:0] wr_data0,
    input wire logic [DATA_W-1:0] wr_data1,
    input wire logic [DATA_W/dpb_pkg::LANE_W-1:0] wr_lane_en0,
    input wire logic [DATA_W/dpb_pkg::LANE_W-1:0] wr_lane_en1,
    output logic rd_data_valid,
    input wire logic rd_data_ready,
    output logic [DATA_W-1:0] rd_data,
    dpb_link_if.ctl link
);
    localparam int LANES = DATA_W / dpb_pkg::LANE_W;
    localparam int FD = dpb_pkg::FIFO_DEPTH;

    generate
        if (DATA_W % dpb_pkg::LANE_W != 0 || FD != dpb_pkg::BURST_LEN) begin : g_bad
            $error("Unsupported width or buffer depth");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Link state
    logic phase_reg;
    logic phase_next;
    logic rps_n_reg;
    logic rps_n_next;
    logic wps_n_reg;
    logic wps_n_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic [LANES-1:0] bws_n_reg;
    logic [LANES-1:0] bws_n_next;
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] wr_addr_next;
    logic [DATA_W-1:0] wr_d1_reg;
    logic [DATA_W-1:0] wr_d1_next;
    logic [LANES-1:0] wr_en1_reg;
    logic [LANES-1:0] wr_en1_next;
    logic rd_busy_reg;
    logic rd_busy_next;
    logic rd_beat_reg;
    logic rd_beat_next;
    logic fifo_empty;
    logic fifo_full;
    logic push;

    // Requests taken only in the complementary phase, pins move at true edge
    assign rd_req_ready = ~phase_reg & ~rd_busy_reg & fifo_empty;
    assign wr_req_ready = ~phase_reg;
    assign push = link.read_valid_flag & ~fifo_full;

    // Link sequencing
    always_comb begin
        phase_next = ~phase_reg;
        rps_n_next = 1'b1;
        wps_n_next = 1'b1;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        bws_n_next = '1;
        wr_pend_next = wr_pend_reg;
        wr_addr_next = wr_addr_reg;
        wr_d1_next = wr_d1_reg;
        wr_en1_next = wr_en1_reg;
        rd_busy_next = rd_busy_reg;
        rd_beat_next = rd_beat_reg;
        if (!phase_reg) begin
            if (rd_req_valid && rd_req_ready) begin
                rps_n_next = 1'b0;
                addr_next = rd_req_addr;
                rd_busy_next = 1'b1;
            end
            if (wr_req_valid) begin
                wps_n_next = 1'b0;
                wdata_next = wr_data0;
                bws_n_next = ~wr_lane_en0;
                wr_pend_next = 1'b1;
                wr_addr_next = wr_req_addr;
                wr_d1_next = wr_data1;
                wr_en1_next = wr_lane_en1;
            end
        end else if (wr_pend_reg) begin
            addr_next = wr_addr_reg;
            wdata_next = wr_d1_reg;
            bws_n_next = ~wr_en1_reg;
            wr_pend_next = 1'b0;
        end
        if (push) begin
            rd_beat_next = ~rd_beat_reg;
            if (rd_beat_reg) begin
                rd_busy_next = 1'b0;
            end
        end
    end

    // Link registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase_reg <= 1'b0;
            rps_n_reg <= 1'b1;
            wps_n_reg <= 1'b1;
            addr_reg <= '0;
            wdata_reg <= '0;
            bws_n_reg <= '1;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_d1_reg <= '0;
            wr_en1_reg <= '0;
            rd_busy_reg <= 1'b0;
            rd_beat_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            rps_n_reg <= rps_n_next;
            wps_n_reg <= wps_n_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            bws_n_reg <= bws_n_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            wr_d1_reg <= wr_d1_next;
            wr_en1_reg <= wr_en1_next;
            rd_busy_reg <= rd_busy_next;
            rd_beat_reg <= rd_beat_next;
        end
    end

    // Pins; input clocks derived from ref_clk by a divide-by-two
    assign link.k_true = phase_reg;
    assign link.k_comp = ~phase_reg;
    assign link.read_port_select_n = rps_n_reg;
    assign link.write_port_select_n = wps_n_reg;
    assign link.addr = addr_reg;
    assign link.wdata = wdata_reg;
    assign link.byte_lane_write_select_n = bws_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry read return buffer
    logic [DATA_W-1:0] fifo_reg [FD];
    logic [DATA_W-1:0] fifo_next [FD];
    logic wptr_reg;
    logic wptr_next;
    logic rptr_reg;
    logic rptr_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic pop;

    assign fifo_empty = (count_reg == 2'h0);
    assign fifo_full = (count_reg == 2'h2);
    assign pop = rd_data_ready & ~fifo_empty;
    assign rd_data_valid = ~fifo_empty;
    assign rd_data = fifo_reg[rptr_reg];

    // Buffer pointer and storage update
    always_comb begin
        fifo_next = fifo_reg;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        if (push) begin
            fifo_next[wptr_reg] = link.q_bus;
            wptr_next = ~wptr_reg;
        end
        if (pop) begin
            rptr_next = ~rptr_reg;
        end
        count_next = count_reg + {1'b0, push} - {1'b0, pop};
    end

    // Buffer registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fifo_reg[0] <= '0;
            fifo_reg[1] <= '0;
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            fifo_reg <= fifo_next;
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
        end
    end
endmodule : dpb_mem_ctl

// >>> verilog/dpb_mem_dev.sv
// Device end: burst memory with separate read and write ports
`timescale 1ns/1ns
module dpb_mem_dev #(
    parameter int DATA_W = dpb_pkg::DATA_W_NARROW,
    parameter int ADDR_W = dpb_pkg::ADDR_W_NARROW,
    parameter int MEM_AW = dpb_pkg::MEM_AW_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    dpb_link_if.dev link
);
    localparam int LANES = DATA_W / dpb_pkg::LANE_W;
    localparam int DEPTH = 1 << MEM_AW;
    localparam int LAT = dpb_pkg::READ_LAT_PHASES;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    generate
        if (DATA_W % dpb_pkg::LANE_W != 0 || LANES < 1) begin : g_bad_width
            $error("Data width must be a whole number of nine-bit lanes");
        end
        if (MEM_AW < 1 || MEM_AW > ADDR_W) begin : g_bad_depth
            $error("Storage address width must lie within the address bus");
        end
        if (LAT < 2) begin : g_bad_lat
            $error("Read latency too short for a two-beat burst");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Byte lane masks
    logic [DATA_W-1:0] lane_mask;

    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            assign lane_mask[gi*dpb_pkg::LANE_W +: dpb_pkg::LANE_W] =
                {dpb_pkg::LANE_W{~link.byte_lane_write_select_n[gi]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Write port state
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [DATA_W-1:0] wr_d0_reg;
    logic [DATA_W-1:0] wr_d0_next;
    logic [DATA_W-1:0] wr_m0_reg;
    logic [DATA_W-1:0] wr_m0_next;
    logic [DATA_W-1:0] mem0_reg [DEPTH];
    logic [DATA_W-1:0] mem0_next [DEPTH];
    logic [DATA_W-1:0] mem1_reg [DEPTH];
    logic [DATA_W-1:0] mem1_next [DEPTH];
    logic [MEM_AW-1:0] wr_idx;

    // Low address bits index the storage
    assign wr_idx = link.addr[MEM_AW-1:0];

    // Write sequencing and byte-masked storage update
    always_comb begin
        wr_pend_next = wr_pend_reg;
        wr_d0_next = wr_d0_reg;
        wr_m0_next = wr_m0_reg;
        mem0_next = mem0_reg;
        mem1_next = mem1_reg;
        if (link.k_true) begin
            wr_pend_next = ~link.write_port_select_n;
            if (!link.write_port_select_n) begin
                wr_d0_next = link.wdata;
                wr_m0_next = lane_mask;
            end
        end else if (wr_pend_reg) begin
            mem0_next[wr_idx] = (mem0_reg[wr_idx] & ~wr_m0_reg) | (wr_d0_reg & wr_m0_reg);
            mem1_next[wr_idx] = (mem1_reg[wr_idx] & ~lane_mask) | (link.wdata & lane_mask);
            wr_pend_next = 1'b0;
        end
    end

    // Write port registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_pend_reg <= 1'b0;
            wr_d0_reg <= '0;
            wr_m0_reg <= '0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_d0_reg <= wr_d0_next;
            wr_m0_reg <= wr_m0_next;
        end
    end

    // Storage array, not cleared by reset
    always_ff @(posedge ref_clk) begin
        mem0_reg <= mem0_next;
        mem1_reg <= mem1_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port state
    logic [LAT-1:0] rd_vld_reg;
    logic [LAT-1:0] rd_vld_next;
    logic [MEM_AW-1:0] rd_addr_reg [LAT];
    logic [MEM_AW-1:0] rd_addr_next [LAT];
    logic [DATA_W-1:0] q_reg;
    logic [DATA_W-1:0] q_next;
    logic q_oe_reg;
    logic q_oe_next;
    logic valid_reg;
    logic valid_next;
    logic echo_reg;
    logic echo_next;
    logic echo_n_reg;
    logic echo_n_next;
    logic [MEM_AW-1:0] beat0_idx;
    logic [MEM_AW-1:0] beat1_idx;

    assign beat0_idx = rd_addr_reg[dpb_pkg::BEAT0_STAGE];
    assign beat1_idx = rd_addr_reg[dpb_pkg::BEAT1_STAGE];

    // Read latency pipeline and output launch
    always_comb begin
        rd_vld_next = {rd_vld_reg[LAT-2:0], 1'b0};
        rd_addr_next[0] = rd_addr_reg[0];
        for (int i = 1; i < LAT; i++) begin
            rd_addr_next[i] = rd_addr_reg[i-1];
        end
        if (link.k_true && !link.read_port_select_n) begin
            rd_vld_next[0] = 1'b1;
            rd_addr_next[0] = link.addr[MEM_AW-1:0];
        end
        q_next = q_reg;
        q_oe_next = 1'b0;
        valid_next = 1'b0;
        if (rd_vld_reg[dpb_pkg::BEAT0_STAGE]) begin
            q_next = mem0_reg[beat0_idx];
            q_oe_next = 1'b1;
            valid_next = 1'b1;
        end else if (rd_vld_reg[dpb_pkg::BEAT1_STAGE]) begin
            q_next = mem1_reg[beat1_idx];
            q_oe_next = 1'b1;
            valid_next = 1'b1;
        end
        // first-beat stage wins over a pending second beat
        // Echo follows the input clock through the output register
        echo_next = link.k_true;
        echo_n_next = ~link.k_true;
    end

    // Read port registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rd_vld_reg <= '0;
            for (int i = 0; i < LAT; i++) begin
                rd_addr_reg[i] <= '0;
            end
            q_reg <= '0;
            q_oe_reg <= 1'b0;
            valid_reg <= 1'b0;
            echo_reg <= 1'b0;
            echo_n_reg <= 1'b1;
        end else begin
            rd_vld_reg <= rd_vld_next;
            rd_addr_reg <= rd_addr_next;
            q_reg <= q_next;
            q_oe_reg <= q_oe_next;
            valid_reg <= valid_next;
            echo_reg <= echo_next;
            echo_n_reg <= echo_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    // flag from same edge as echo
    assign link.read_valid_flag = valid_reg;
    assign link.echo_timing_output = echo_reg;
    assign link.echo_timing_output_n = echo_n_reg;
    assign link.q_out = q_reg;
    assign link.q_oe = q_oe_reg;
endmodule : dpb_mem_dev

// >>> verilog/dpb_pkg.sv
// Shared constants of the burst memory link and its two ends
package dpb_pkg;
    // Lane and organisation widths
    localparam int LANE_W = 9;
    localparam int DATA_W_NARROW = 18;
    localparam int ADDR_W_NARROW = 20;
    localparam int DATA_W_WIDE = 36;
    localparam int ADDR_W_WIDE = 19;
    // Words moved per address
    localparam int BURST_LEN = 2;
    // Read latency, in tenths of an input clock cycle as printed (2.5)
    localparam int READ_LAT_TENTHS = 25;
    // One half input clock cycle is one ref_clk cycle
    localparam int PHASES_PER_CYCLE = 2;
    localparam int READ_LAT_PHASES = READ_LAT_TENTHS * PHASES_PER_CYCLE / 10;
    // Pipeline stages that launch the first and second beat
    localparam int BEAT0_STAGE = READ_LAT_PHASES - 2;
    localparam int BEAT1_STAGE = READ_LAT_PHASES - 1;
    // Default storage address width (16 words deep) kept in flip-flops
    localparam int MEM_AW_DEF = 4;
    // Read return buffer depth
    localparam int FIFO_DEPTH = 2;
    // Reference clock period in ns
    localparam int REF_CLK_NS = 40;
endpackage : dpb_pkg
